// *** rtl/sysref_lmfc_link_timing.sv ***
`timescale 1ns/10ps
module sysref_lmfc_link_timing
  import link_timing_pkg::*;
#(
  parameter longint CAL_TRIM_CYCLES = CAL_CYCLES_TRIM,
  parameter longint CAL_NOTRIM_CYCLES = CAL_CYCLES_NOTRIM
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sysref,
  input wire logic sync_n,
  input wire link_cfg_t cfg,
  input wire logic [1:0] prop_extra,
  input wire logic cal_start,
  input wire logic auto_trim,
  output logic lmfc_edge,
  output logic frame_start,
  output logic ila_active,
  output logic data_active,
  output logic cal_busy,
  output logic cal_done
);
  logic sysref_q;
  logic sysref_rise;
  logic [5:0] ref_cnt;
  logic ref_pend;
  logic lmfc_align;
  logic [5:0] frames;
  logic [4:0] octets;
  logic [3:0] oct_clks;
  logic [12:0] lmfc_cnt;
  logic [12:0] lmfc_period;
  logic lmfc_tick;
  logic [6:0] tx_cnt;
  logic tx_pend;
  logic mf_tick;
  logic mf_start;
  link_state_t state;
  logic [2:0] ila_cnt;
  logic wait_hit;
  logic ila_last;
  cal_state_t cal_state;
  logic [27:0] cal_cnt;
  logic [27:0] cal_load;

  // Sysref captured on device clock edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sysref_q <= 1'b0;
    end else begin
      sysref_q <= sysref;
    end
  end
  assign sysref_rise = sysref & ~sysref_q;

  // Count forty cycles to the boundary; new edge restarts, fine since source holds 8 high
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ref_cnt <= 6'h00;
      ref_pend <= 1'b0;
    end else if (sysref_rise) begin
      ref_cnt <= SYSREF_TO_LMFC - 6'h01;
      ref_pend <= 1'b1;
    end else if (ref_pend) begin
      ref_cnt <= ref_cnt - 6'h01;
      if (ref_cnt == 6'h01) ref_pend <= 1'b0;
    end
  end
  assign lmfc_align = ref_pend && (ref_cnt == 6'h01);

  // LMFC period from frame and octet settings
  assign frames = 6'(cfg.frames_per_multiframe_m1) + 6'h01;
  assign octets = 5'(cfg.octets_per_frame_m1) + 5'h01;
  assign oct_clks = octet_clocks(cfg.double_rate_setting, cfg.five_four_rate_setting);
  // Thirteen bits hold the largest product, 32 by 16 by 10
  assign lmfc_period = 13'(frames * octets * oct_clks);

  // Free running LMFC counter, phased by sysref
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lmfc_cnt <= 13'h0000;
    end else if (lmfc_align || lmfc_cnt + 13'h0001 >= lmfc_period) begin
      lmfc_cnt <= 13'h0000;
    end else begin
      lmfc_cnt <= lmfc_cnt + 13'h0001;
    end
  end
  assign lmfc_tick = lmfc_align || (lmfc_cnt + 13'h0001 >= lmfc_period && lmfc_period != 13'h0000);

  // Boundary pulse, registered like every other output
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lmfc_edge <= 1'b0;
    end else begin
      lmfc_edge <= lmfc_tick;
    end
  end

  // Mode delay from boundary to multiframe start; restarts each boundary
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_cnt <= 7'h00;
      tx_pend <= 1'b0;
    end else if (lmfc_tick) begin
      tx_cnt <= tx_delay_cycles(cfg.double_rate_setting, cfg.five_four_rate_setting);
      tx_pend <= 1'b1;
    end else if (tx_pend) begin
      tx_cnt <= tx_cnt - 7'h01;
      if (tx_cnt == 7'h01) tx_pend <= 1'b0;
    end
  end
  assign mf_tick = tx_pend && (tx_cnt == 7'h01); // Last count, so the whole delay elapses

  delay_line u_prop (
    .core_clk(core_clk),
    .rst(rst),
    .extra(prop_extra),
    .din(mf_tick),
    .dout(mf_start)
  );

  // Frame start pulse after the optional extra delay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      frame_start <= 1'b0;
    end else begin
      frame_start <= mf_start;
    end
  end

  // Link sequencer: sync request, wait, lane alignment, data
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= LINK_SYNC;
      ila_cnt <= 3'h0;
    end else if (!sync_n) begin
      state <= LINK_SYNC; // receiver keeps low long enough
      ila_cnt <= 3'h0;
    end else begin
      case (state)
        LINK_SYNC: begin
          state <= LINK_WAIT;
        end
        LINK_WAIT: begin
          if (mf_start) begin
            state <= LINK_ILA;
            ila_cnt <= ILA_MULTIFRAMES - 3'h1;
          end
        end
        LINK_ILA: begin
          if (mf_start) begin
            if (ila_cnt == 3'h0) state <= LINK_DATA;
            else ila_cnt <= ila_cnt - 3'h1;
          end
        end
        default: begin
          state <= LINK_DATA;
        end
      endcase
    end
  end

  // First and last multiframe starts of the alignment phase
  assign wait_hit = (state == LINK_WAIT) && mf_start;
  assign ila_last = (state == LINK_ILA) && mf_start && (ila_cnt == 3'h0);

  // Alignment flag rises with the first frame start, so it spans four whole multiframes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ila_active <= 1'b0;
    end else begin
      ila_active <= sync_n && (wait_hit || (state == LINK_ILA && !ila_last));
    end
  end

  // Data phase takes over on the very edge where alignment ends
  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_active <= 1'b0;
    end else begin
      data_active <= sync_n && (state == LINK_DATA || ila_last);
    end
  end

  // Length taken once at start; later changes of auto_trim do not stretch a run
  assign cal_load = 28'(auto_trim ? CAL_TRIM_CYCLES - 1 : CAL_NOTRIM_CYCLES - 1);

  // Foreground calibration timer; counts not restartable while busy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_state <= CAL_IDLE;
      cal_cnt <= 28'h0000000;
      cal_busy <= 1'b0;
    end else begin
      case (cal_state)
        CAL_IDLE: begin
          if (cal_start) begin
            cal_cnt <= cal_load;
            cal_state <= CAL_RUN;
            cal_busy <= 1'b1;
          end
        end
        default: begin
          if (cal_cnt == 28'h0000000) begin
            cal_state <= CAL_IDLE;
            cal_busy <= 1'b0;
          end else begin
            cal_cnt <= cal_cnt - 28'h0000001;
          end
        end
      endcase
    end
  end

  // Done pulse in its own flop, raised on the edge that drops busy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cal_done <= 1'b0;
    end else begin
      cal_done <= (cal_state == CAL_RUN) && (cal_cnt == 28'h0000000);
    end
  end
endmodule

// *** rtl/link_timing_pkg.sv ***
// Operation
// - Sample sysref on rising device clock edge
// - LMFC boundary forty periods after sysref high
// - Frame start follows boundary by mode delay
// - Extra propagation delay of zero to three
// - Lane alignment lasts four multiframe periods
// - Calibration takes 227M or 102M cycles
package link_timing_pkg;
  // Device clock core_clk: 250 MHz, 4 ns
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SYSREF_HOLD_PERIODS = 8;
  localparam logic [5:0] SYSREF_TO_LMFC = 6'h28;
  // Functional delays in tenths of a device clock period
  localparam int TX_DLY_X10_BASE = 607;
  localparam int TX_DLY_X10_FIVE_FOUR = 515;
  localparam int TX_DLY_X10_DDR = 527;
  localparam int TX_DLY_X10_BOTH = 439;
  localparam logic [1:0] PROP_DLY_MAX = 2'h3;
  localparam logic [2:0] ILA_MULTIFRAMES = 3'h4;
  localparam logic [2:0] SYNC_MIN_FRAMES = 3'h4;
  localparam longint CAL_CYCLES_TRIM = 64'hD87BEC0; // 227 million
  localparam longint CAL_CYCLES_NOTRIM = 64'h6146580; // 102 million
  // Device clocks per octet, by lane rate setting
  localparam logic [3:0] OCT_CLK_BASE = 4'hA;
  localparam logic [3:0] OCT_CLK_FIVE_FOUR = 4'h8;
  localparam logic [3:0] OCT_CLK_DDR = 4'h5;
  localparam logic [3:0] OCT_CLK_BOTH = 4'h4;

  typedef struct packed {
    logic double_rate_setting;
    logic five_four_rate_setting;
    logic [4:0] frames_per_multiframe_m1;
    logic [3:0] octets_per_frame_m1;
  } link_cfg_t;

  typedef enum logic [1:0] {
    LINK_SYNC = 2'b00,
    LINK_WAIT = 2'b01,
    LINK_ILA = 2'b10,
    LINK_DATA = 2'b11
  } link_state_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01
  } cal_state_t;

  // Delay rounded up to whole cycles
  function automatic logic [6:0] tx_delay_cycles(input logic ddr, input logic p54);
    int x10;
    x10 = ddr ? (p54 ? TX_DLY_X10_BOTH : TX_DLY_X10_DDR) : (p54 ? TX_DLY_X10_FIVE_FOUR : TX_DLY_X10_BASE);
    return 7'((x10 + 9) / 10);
  endfunction

  function automatic logic [3:0] octet_clocks(input logic ddr, input logic p54);
    return ddr ? (p54 ? OCT_CLK_BOTH : OCT_CLK_DDR) : (p54 ? OCT_CLK_FIVE_FOUR : OCT_CLK_BASE);
  endfunction
endpackage

// *** rtl/delay_line.sv ***
`timescale 1ns/10ps
module delay_line
  import link_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] extra,
  input wire logic din,
  output logic dout
);
  logic [2:0] taps;

  // Shift line; tap picks 0..3 extra cycles
  always_ff @(posedge core_clk) begin
    if (rst) begin
      taps <= 3'h0;
    end else begin
      taps <= {taps[1:0], din};
    end
  end

  assign dout = (extra == 2'h0) ? din : taps[extra - 2'h1];
endmodule

// *** tb/link_timing_sva.sv ***
`timescale 1ns/10ps
module link_timing_sva (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sysref,
  input wire logic sync_n,
  input wire logic cal_start,
  input wire logic lmfc_edge,
  input wire logic frame_start,
  input wire logic ila_active,
  input wire logic data_active,
  input wire logic cal_busy,
  input wire logic cal_done
);
  logic [7:0] since_lmfc;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Saturates so a frame start with no boundary before it fails
  always_ff @(posedge core_clk) begin
    if (rst) begin
      since_lmfc <= 8'hFF;
    end else if (lmfc_edge) begin
      since_lmfc <= 8'h00;
    end else if (since_lmfc != 8'hFF) begin
      since_lmfc <= since_lmfc + 8'h01;
    end
  end
  AST_LMFC_DLY: assert property ($rose(sysref) |-> ##40 lmfc_edge)
    else $error("boundary not forty cycles after sysref");
  AST_FRAME_WIN: assert property (frame_start |-> since_lmfc >= 8'h2B && since_lmfc <= 8'h3F)
    else $error("frame start outside delay window");
  AST_LMFC_PULSE: assert property (lmfc_edge |=> !lmfc_edge)
    else $error("boundary pulse too long");
  AST_EXCL: assert property (!(ila_active && data_active))
    else $error("alignment and data overlap");
  AST_SYNC: assert property (!sync_n |=> !ila_active && !data_active)
    else $error("link not held in sync");
  AST_CAL_GO: assert property (cal_start && !cal_busy |=> cal_busy)
    else $error("calibration did not start");
  AST_CAL_END: assert property (cal_done |-> !cal_busy && $past(cal_busy))
    else $error("done without busy falling");
  AST_CAL_HOLD: assert property (cal_busy |=> cal_busy || cal_done)
    else $error("busy dropped without done");
endmodule

// *** tb/link_partner.sv ***
`timescale 1ns/10ps
module link_partner (
  input wire logic core_clk,
  output logic sysref,
  output logic sync_n
);
  // Link held in sync until released
  initial begin
    sysref = 1'b0;
    sync_n = 1'b0;
  end
  task automatic sysref_pulse();
    @(posedge core_clk);
    #1 sysref = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 sysref = 1'b0;
  endtask
  task automatic sync_low();
    sync_n = 1'b0;
  endtask
  // Four whole frames low before release
  task automatic sync_release(input int frame_clks);
    repeat (4 * frame_clks) @(posedge core_clk);
    #1 sync_n = 1'b1;
  endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
  import link_timing_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic cal_start = 1'b0;
  logic auto_trim = 1'b0;
  logic [1:0] prop_extra = 2'h0;
  link_cfg_t cfg = '0;
  logic sysref, sync_n, lmfc_edge, frame_start, ila_active, data_active, cal_busy, cal_done;
  int n_fail = 0;
  int samples_checked = 0;
  int n;
  always #2 core_clk = ~core_clk;
  link_partner rx (.core_clk, .sysref, .sync_n);
  sysref_lmfc_link_timing #(.CAL_TRIM_CYCLES(20), .CAL_NOTRIM_CYCLES(10)) DUT (.core_clk, .rst, .sysref,
    .sync_n, .cfg, .prop_extra, .cal_start, .auto_trim, .lmfc_edge, .frame_start, .ila_active, .data_active,
    .cal_busy, .cal_done);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t ns: saw %0d, expected %0d", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return lmfc_edge;
      1: return frame_start;
      2: return ila_active;
      default: return cal_busy;
    endcase
  endfunction
  // Bounded, so a silent output cannot hang the run
  task automatic wait_sig(input int w, input logic v, output int cnt);
    cnt = 0;
    do begin
      @(posedge core_clk);
      #1;
      cnt++;
    end while (pick(w) !== v && cnt < 2000);
  endtask
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Each rate mode after a fresh reset, then both calibration lengths
  initial begin
    int oc;
    for (int m = 0; m < 4; m++) begin
      rst = 1'b1;
      rx.sync_low();
      cfg = {m[1], m[0], 5'h07, 4'h3};
      prop_extra = m[1:0];
      oc = (m == 0) ? 10 : (m == 1) ? 8 : (m == 2) ? 5 : 4;
      repeat (6) @(posedge core_clk);
      #1 rst = 1'b0;
      rx.sysref_pulse();
      wait_sig(0, 1'b1, n);
      check(n, 32'(SYSREF_TO_LMFC) - SYSREF_HOLD_PERIODS);
      wait_sig(0, 1'b1, n);
      check(n, 32 * oc);
      wait_sig(1, 1'b1, n);
      check(n, ((m == 0) ? 61 : (m == 1) ? 52 : (m == 2) ? 53 : 44) + m);
      rx.sync_release(4 * oc);
      wait_sig(2, 1'b1, n);
      check(frame_start, 1'b1);
      wait_sig(2, 1'b0, n);
      check(n, 4 * 32 * oc);
      check(data_active, 1'b1);
    end
    for (int t = 0; t < 2; t++) begin
      auto_trim = t[0];
      cal_start = 1'b1;
      wait_sig(3, 1'b1, n);
      repeat (2) @(posedge core_clk);
      #1 cal_start = 1'b0;
      wait_sig(3, 1'b0, n);
      check(n + 2, t ? 20 : 10);
      check(cal_done, 1'b1);
    end
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule
bind sysref_lmfc_link_timing link_timing_sva chk (.core_clk, .rst, .sysref, .sync_n, .cal_start, .lmfc_edge,
  .frame_start, .ila_active, .data_active, .cal_busy, .cal_done);
